// file: core/pgc_map.svh
// Register map constants for the pattern colour byte bank.
// Assumes a 32-bit AXI4-Lite slave, one register per aligned word.
`ifndef PGC_MAP_SVH
`define PGC_MAP_SVH

// Register indices; byte address is four times the index
`define PGC_IDX_COLOR_0   5'h10
`define PGC_IDX_COLOR_3   5'h13
`define PGC_IDX_COLOR_4   5'h14
`define PGC_IDX_COLOR_5   5'h15
`define PGC_IDX_COLOR_6   5'h16
`define PGC_IDX_COLOR_7   5'h17
`define PGC_IDX_COLOR_8   5'h18
`define PGC_IDX_COLOR_9   5'h19
`define PGC_IDX_COLOR_10  5'h1A
`define PGC_IDX_COLOR_11  5'h1B
`define PGC_IDX_COLOR_12  5'h1C
`define PGC_IDX_COLOR_13  5'h1D
`define PGC_IDX_COLOR_14  5'h1E
`define PGC_IDX_COLOR_15  5'h1F

// Index field inside the byte address
`define PGC_IDX_LSB       2
`define PGC_IDX_MSB       6
`define PGC_ADDR_W        7

// Reset values
`define PGC_RST_COLOR_0   8'hAA
`define PGC_RST_COLOR_3   8'h7F
`define PGC_RST_COLOR_4   8'h55
`define PGC_RST_COLOR_5   8'hCC
`define PGC_RST_COLOR_6   8'h0F
`define PGC_RST_COLOR_7   8'h80
`define PGC_RST_COLOR_HI  8'h00

// Bus responses
`define PGC_RESP_OKAY     2'h0
`define PGC_RESP_SLVERR   2'h2

`endif

// file: core/pgc_pkg.sv
// Types shared by the pattern colour byte bank.
// Assumes pgc_map.svh is in the include path.
package pgc_pkg;

  typedef logic [7:0] pgc_byte_type;
  typedef logic [15:0][7:0] pgc_bank_type;

  typedef struct packed {
    pgc_bank_type color;
    logic         aw_held;
    logic [6:0]   aw_addr;
    logic         w_held;
    logic [7:0]   w_data;
    logic         w_lane0;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } pgc_state_type;

  typedef struct packed {
    pgc_byte_type bar_byte;
    pgc_byte_type fixed_byte;
  } pgc_pick_type;

endpackage

// file: core/pgc_byte_pick.sv
// Registered selector of the colour byte for bar and fixed patterns.
// Assumes the bank input already holds all sixteen colour bytes.
`timescale 1ns/1ps
`default_nettype none

module pgc_byte_pick
  import pgc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire pgc_bank_type bank,
  input  wire logic [2:0]   bar_sel,
  input  wire logic [3:0]   fixed_sel,
  output logic [7:0]        bar_byte,
  output logic [7:0]        fixed_byte
);

  pgc_pick_type s_r;
  pgc_pick_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    // Bars use colours 0 to 7 only
    s_nxt.bar_byte   = bank[{1'b0, bar_sel}];
    // Fixed pattern walks all sixteen bytes
    s_nxt.fixed_byte = bank[fixed_sel];
    if (!rstn)
    begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_r <= s_nxt;
  end

  assign bar_byte   = s_r.bar_byte;
  assign fixed_byte = s_r.fixed_byte;

endmodule // pgc_byte_pick

`default_nettype wire

// file: core/pgc_color_bank.sv
// Colour byte register bank with an AXI4-Lite slave and pattern taps.
// Assumes one clock, synchronous active-low reset, a 32-bit bus master.
`timescale 1ns/1ps
`default_nettype none

`include "pgc_map.svh"

// Notes on behaviour
// R01: Colour 3 resets 7F; feeds bar 3 and fixed byte four.
// R02: Colour 4 resets 55; feeds bar 4 and fixed byte five.
// R03: Colour 5 resets CC; feeds bar 5 and fixed byte six.
// R04: Colour 6 resets 0F; feeds bar 6 and fixed byte seven.
// R05: Colour 7 resets 80; feeds bar 7 and fixed byte eight.
// R06: Colour 8 resets 00; fixed byte nine only, no bar role.
// R07: Colour 9 resets zero; fixed byte ten.
// R08: Colour 10 resets zero; fixed byte eleven.
// R09: Colour 11 resets zero; fixed byte twelve.
// R10: Colour 12 resets zero; fixed byte thirteen.
// R11: Colour 13 resets zero; fixed byte fourteen.
// R12: Colour 14 resets zero; fixed byte fifteen.
// R13: Colour 15 resets zero; fixed byte sixteen, the last.
// R14: Colour 0 resets AA; feeds bar 0 and first fixed byte.
// R15: Reads return last full byte written; writes touch one register only.
module pgc_color_bank
  import pgc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [6:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [6:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  color_byte_1,
  input  wire logic [7:0]  color_byte_2,
  input  wire logic [2:0]  bar_sel,
  input  wire logic [3:0]  fixed_sel,
  output logic [7:0]       bar_byte,
  output logic [7:0]       fixed_byte
);

  pgc_state_type s_r;
  pgc_state_type s_nxt;
  pgc_bank_type  tap_bank;
  logic          wr_fire;
  logic [4:0]    wr_idx;
  logic [4:0]    rd_idx;

  // Index of an aligned word address
  function automatic logic [4:0] word_index(input logic [6:0] addr);
    word_index = addr[`PGC_IDX_MSB:`PGC_IDX_LSB];
  endfunction

  // True where the bank holds a register
  function automatic logic is_mapped(input logic [6:0] addr);
    logic [4:0] idx;
    idx = addr[`PGC_IDX_MSB:`PGC_IDX_LSB];
    if (addr[1:0] != 2'h0)
    begin
      is_mapped = 1'b0;
    end
    else if (idx == `PGC_IDX_COLOR_0)
    begin
      is_mapped = 1'b1;
    end
    else if ((idx >= `PGC_IDX_COLOR_3) && (idx <= `PGC_IDX_COLOR_15))
    begin
      is_mapped = 1'b1;
    end
    else
    begin
      is_mapped = 1'b0;
    end
  endfunction

  // Reset contents of the bank
  function automatic pgc_bank_type reset_bank();
    pgc_bank_type b;
    b     = '0;
    b[0]  = `PGC_RST_COLOR_0;  // R14
    b[3]  = `PGC_RST_COLOR_3;  // R01
    b[4]  = `PGC_RST_COLOR_4;  // R02
    b[5]  = `PGC_RST_COLOR_5;  // R03
    b[6]  = `PGC_RST_COLOR_6;  // R04
    b[7]  = `PGC_RST_COLOR_7;  // R05
    b[8]  = `PGC_RST_COLOR_HI; // R06
    b[9]  = `PGC_RST_COLOR_HI; // R07
    b[10] = `PGC_RST_COLOR_HI; // R08
    b[11] = `PGC_RST_COLOR_HI; // R09
    b[12] = `PGC_RST_COLOR_HI; // R10
    b[13] = `PGC_RST_COLOR_HI; // R11
    b[14] = `PGC_RST_COLOR_HI; // R12
    b[15] = `PGC_RST_COLOR_HI; // R13
    reset_bank = b;
  endfunction

  assign wr_fire = s_r.aw_held && s_r.w_held && !s_r.bvalid;
  assign wr_idx  = word_index(s_r.aw_addr);
  assign rd_idx  = word_index(s_axi_araddr);

  always_comb
  begin
    s_nxt = s_r;

    // Write address channel
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end

    // Write data channel
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_data  = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end

    // Commit once both halves are held
    if (wr_fire)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      if (is_mapped(s_r.aw_addr))
      begin
        s_nxt.bresp = `PGC_RESP_OKAY;
        if (s_r.w_lane0)
        begin
          s_nxt.color[wr_idx[3:0]] = s_r.w_data; // R15
        end
      end
      else
      begin
        s_nxt.bresp = `PGC_RESP_SLVERR;
      end
    end

    // Write response
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
      s_nxt.bresp  = `PGC_RESP_OKAY;
    end

    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

    // Read address channel
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      if (is_mapped(s_axi_araddr))
      begin
        s_nxt.rdata = {24'h00_0000, s_r.color[rd_idx[3:0]]}; // R15
        s_nxt.rresp = `PGC_RESP_OKAY;
      end
      else
      begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = `PGC_RESP_SLVERR;
      end
    end
    else if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
      s_nxt.rdata  = 32'h0000_0000;
      s_nxt.rresp  = `PGC_RESP_OKAY;
    end

    s_nxt.arready = !s_nxt.rvalid;

    if (!rstn)
    begin
      s_nxt         = '0;
      s_nxt.color   = reset_bank();
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
      s_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_r <= s_nxt;
  end

  // Pattern view of the bank; colours 1 and 2 live elsewhere
  always_comb
  begin
    tap_bank    = s_r.color; // R01 R02 R03 R04 R05 R14
    tap_bank[1] = color_byte_1;
    tap_bank[2] = color_byte_2;
  end

  pgc_byte_pick u_pick
  (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .bank       (tap_bank),
    .bar_sel    (bar_sel),
    .fixed_sel  (fixed_sel), // R06 R07 R08 R09 R10 R11 R12 R13
    .bar_byte   (bar_byte),
    .fixed_byte (fixed_byte)
  );

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

endmodule // pgc_color_bank

`default_nettype wire

// file: test/pgc_color_bank_assertions.sv
// Port checks for the colour byte bank, bound into its top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "pgc_map.svh"

module pgc_color_bank_assertions (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [6:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  bar_sel,
  input wire logic [3:0]  fixed_sel,
  input wire logic [7:0]  bar_byte,
  input wire logic [7:0]  fixed_byte
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence both_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_late_s;
    !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  wr_resp_time_a: assert property (both_taken_s |=> resp_late_s)
    else $error("write response timing wrong");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 7'h44
    |=> s_axi_rresp == `PGC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  reset_ready_a: assert property ($rose(rstn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid)
    else $error("bus not idle after reset");
  tap_agree_a: assert property (bar_sel == fixed_sel[2:0] && !fixed_sel[3] |=> bar_byte == fixed_byte)
    else $error("bar and fixed taps disagree");
endmodule // pgc_color_bank_assertions

bind pgc_color_bank pgc_color_bank_assertions pgc_color_bank_assertions_inst (
  .sys_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bar_sel, .fixed_sel, .bar_byte, .fixed_byte
);
`default_nettype wire

// file: test/test_pgc_color_bank.sv
// Self-checking bench for the colour byte bank.
// Assumes package, map header and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pgc_map.svh"
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin n_errors++; \
  $display("ERROR %0t: got %h want %h", $time, g, w); end end

module test_pgc_color_bank;
  logic        sys_clk = 1'b0, rstn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [6:0]  s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb = 4'h0, fixed_sel = 4'h0;
  logic [2:0]  bar_sel = 3'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic [7:0]  bar_byte, fixed_byte;
  int          n_errors = 0, n_compared = 0;
  // Index beside reset value
  logic [12:0] rows [14] = '{13'h10aa, 13'h137f, 13'h1455, 13'h15cc, 13'h160f, 13'h1780,
    13'h1800, 13'h1900, 13'h1a00, 13'h1b00, 13'h1c00, 13'h1d00, 13'h1e00, 13'h1f00};

  pgc_color_bank pgc_color_bank_inst (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .color_byte_1(8'h33),
    .color_byte_2(8'hf0), .bar_sel, .fixed_sel, .bar_byte, .fixed_byte
  );

  always #10 sys_clk = ~sys_clk;

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 17) ^ 8'h3c;
  endfunction

  task automatic wr(input logic [4:0] i, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic check_resets;
    for (int k = 0; k < 14; k++)
    begin
      rd(rows[k][12:8], rd_d, rd_r);
      `CHK(rd_d, {24'h00_0000, rows[k][7:0]})
    end
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    check_resets();
    for (int k = 0; k < 14; k++)
    begin
      wr(rows[k][12:8], pat(k), 4'h1, rd_r);
      `CHK(rd_r, `PGC_RESP_OKAY)
    end
    for (int k = 0; k < 14; k++)
    begin
      rd(rows[k][12:8], rd_d, rd_r);
      `CHK(rd_d, {24'h00_0000, pat(k)})
      fixed_sel <= rows[k][11:8];
      bar_sel <= rows[k][10:8];
      repeat (2) @(posedge sys_clk);
      `CHK(fixed_byte, pat(k))
      if (k < 6) `CHK(bar_byte, pat(k))
    end
    wr(5'h13, 8'hff, 4'h0, rd_r);
    `CHK(rd_r, `PGC_RESP_OKAY)
    rd(5'h13, rd_d, rd_r);
    `CHK(rd_d, {24'h00_0000, pat(1)})
    // Colours 1 and 2 come in on ports
    fixed_sel <= 4'h1;
    bar_sel <= 3'h2;
    repeat (2) @(posedge sys_clk);
    `CHK(fixed_byte, 8'h33)
    `CHK(bar_byte, 8'hf0)
    wr(5'h12, 8'hff, 4'h1, rd_r);
    `CHK(rd_r, `PGC_RESP_SLVERR)
    rd(5'h11, rd_d, rd_r);
    `CHK(rd_r, `PGC_RESP_SLVERR)
    `CHK(rd_d, 32'h0000_0000)
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    check_resets();
    tally_and_finish();
  end

  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule // test_pgc_color_bank
`default_nettype wire
